/* File: rtl/bypass_pkg.sv */
package bypass_pkg;
  localparam int unsigned CLK_MHZ      = 20;
  localparam int unsigned LOSS_MAX_NS  = 400;
  localparam int unsigned LOSS_MAX_CYC = (LOSS_MAX_NS * CLK_MHZ) / 1000;

  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0]  OFF_CTRL = 8'h00;
  localparam logic [7:0]  OFF_SRC  = 8'h04;
  localparam logic [7:0]  OFF_STAT = 8'h08;
  localparam logic [7:0]  OFF_MASK = 8'h0c;

  localparam int unsigned BIT_EN  = 7;
  localparam int unsigned BIT_IEN = 6;
  localparam int unsigned BIT_FB  = 1;
  localparam int unsigned BIT_SD  = 0;
  localparam int unsigned BIT_EVT = 0;

  localparam logic        EN_RST   = 1'b0;
  localparam logic        IEN_RST  = 1'b0;
  localparam logic        FB_RST   = 1'b1;
  localparam logic        PIN_RST  = 1'b1;
  localparam logic        MASK_RST = 1'b1;
  localparam logic [7:0]  SRC_NONE = 8'h00;
  localparam logic [7:0]  SLOT_ADDR_DEF = 8'h26;

  localparam int unsigned PIN_SD  = 0;
  localparam int unsigned PIN_OUT = 1;

  typedef enum logic [2:0] {SEL_CTRL, SEL_SRC, SEL_STAT, SEL_MASK, SEL_NONE} reg_sel_t;
endpackage

/* File: rtl/pin_sync_if.sv */
`timescale 1ns/10ps
interface pin_sync_if #(parameter int W = 2);
  logic [W-1:0] filt;
  modport src (output filt);
  modport dst (input  filt);
endinterface

/* File: rtl/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] din,
  pin_sync_if.src           sif
);
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic s1_q, s2_q, s3_q, filt_q, filt_d;
      // New level counts once stages two and three agree
      always_comb
      begin
        filt_d = filt_q;
        if (s2_q == s3_q)
        begin
          filt_d = s3_q;
        end
      end
      // Three-stage chain, reset to the pulled-up level
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          s1_q   <= bypass_pkg::PIN_RST;
          s2_q   <= bypass_pkg::PIN_RST;
          s3_q   <= bypass_pkg::PIN_RST;
          filt_q <= bypass_pkg::PIN_RST;
        end
        else
        begin
          s1_q   <= din[g];
          s2_q   <= s1_q;
          s3_q   <= s2_q;
          filt_q <= filt_d;
        end
      end
      assign sif.filt[g] = filt_q;
    end
  endgenerate
endmodule // pin_sync

/* File: rtl/bypass_slot.sv */
`timescale 1ns/10ps
module bypass_slot #(
  parameter logic [7:0] SLOT_ADDR = bypass_pkg::SLOT_ADDR_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        bypass_out_pin_i,
  output logic             bypass_out_pin_o,
  output logic             bypass_out_pin_oe,
  input  wire logic        detect_in_pin,
  output logic             irq_n
);
  // Address decode shared by read and write paths
  function automatic bypass_pkg::reg_sel_t decode(input logic [7:0] a);
    if (a == bypass_pkg::OFF_CTRL)
      return bypass_pkg::SEL_CTRL;
    else if (a == bypass_pkg::OFF_SRC)
      return bypass_pkg::SEL_SRC;
    else if (a == bypass_pkg::OFF_STAT)
      return bypass_pkg::SEL_STAT;
    else if (a == bypass_pkg::OFF_MASK)
      return bypass_pkg::SEL_MASK;
    else
      return bypass_pkg::SEL_NONE;
  endfunction

  pin_sync_if #(.W(2)) sif ();

  logic                 filt_sd;
  logic                 filt_out;
  bypass_pkg::reg_sel_t sel;
  logic                 setup;
  logic                 acc;
  logic                 wr_ctrl;
  logic                 wr_stat;
  logic                 wr_mask;
  logic                 sd_chg;
  logic                 sd_evt;
  logic [7:0]           ctrl_rd;

  logic        en_q, en_d, ien_q, ien_d, fb_q, fb_d;
  logic        sd_prev_q, sd_prev_d;
  logic        stat_q, stat_d, mask_q, mask_d;
  logic [7:0]  src_q, src_d;
  logic        irq_n_q, irq_n_d;
  logic        out_q, out_d, oe_q, oe_d;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d;

  // Both pins pass the synchronizer and filter
  pin_sync #(.W(2)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({bypass_out_pin_i, detect_in_pin}),
    .sif     (sif.src)
  );

  assign filt_sd  = sif.filt[bypass_pkg::PIN_SD];
  assign filt_out = sif.filt[bypass_pkg::PIN_OUT];

  // APB phase and strobe decode
  assign sel     = decode(paddr);
  assign setup   = psel && !penable;
  assign acc     = psel && penable && pready_q;
  assign wr_ctrl = acc && pwrite && (sel == bypass_pkg::SEL_CTRL);
  assign wr_stat = acc && pwrite && (sel == bypass_pkg::SEL_STAT);
  assign wr_mask = acc && pwrite && (sel == bypass_pkg::SEL_MASK);

  // Detect edge qualified by enable and irq enable
  assign sd_chg = filt_sd ^ sd_prev_q;
  assign sd_evt = sd_chg && en_q && ien_q;

  // Control register view; reserved bits read zero
  assign ctrl_rd = {en_q, ien_q, 4'h0,
                    en_q ? fb_q : filt_out,
                    filt_sd};

  // Control bits next state
  always_comb
  begin
    en_d  = en_q;
    ien_d = ien_q;
    fb_d  = fb_q;
    if (wr_ctrl)
    begin
      en_d  = pwdata[bypass_pkg::BIT_EN];
      ien_d = pwdata[bypass_pkg::BIT_IEN];
      fb_d  = pwdata[bypass_pkg::BIT_FB];
    end
    if (!filt_sd)
    begin
      fb_d = 1'b0;
    end
  end

  // Control bits storage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q  <= bypass_pkg::EN_RST;
      ien_q <= bypass_pkg::IEN_RST;
      fb_q  <= bypass_pkg::FB_RST;
    end
    else
    begin
      en_q  <= en_d;
      ien_q <= ien_d;
      fb_q  <= fb_d;
    end
  end

  // Interrupt status, source and mask next state
  always_comb
  begin
    sd_prev_d = filt_sd;
    stat_d    = stat_q;
    src_d     = src_q;
    mask_d    = mask_q;
    if (wr_mask)
    begin
      mask_d = pwdata[bypass_pkg::BIT_EVT];
    end
    if (wr_stat && pwdata[bypass_pkg::BIT_EVT])
    begin
      stat_d = 1'b0;
      src_d  = bypass_pkg::SRC_NONE;
    end
    if (sd_evt)
    begin
      stat_d = 1'b1;
      src_d  = SLOT_ADDR;
    end
    irq_n_d = !(stat_d && mask_d);
  end

  // Interrupt storage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sd_prev_q <= bypass_pkg::PIN_RST;
      stat_q    <= 1'b0;
      src_q     <= bypass_pkg::SRC_NONE;
      mask_q    <= bypass_pkg::MASK_RST;
      irq_n_q   <= 1'b1;
    end
    else
    begin
      sd_prev_q <= sd_prev_d;
      stat_q    <= stat_d;
      src_q     <= src_d;
      mask_q    <= mask_d;
      irq_n_q   <= irq_n_d;
    end
  end

  // Pin drive: high keeps the bypass off, low forces bypass
  always_comb
  begin
    out_d = fb_d;
    oe_d  = en_d;
  end

  // Pin drive storage; reset leaves the pin an input
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_q <= bypass_pkg::FB_RST;
      oe_q  <= 1'b0;
    end
    else
    begin
      out_q <= out_d;
      oe_q  <= oe_d;
    end
  end

  // APB answer: ready in the first access cycle, data caught at setup
  always_comb
  begin
    pready_d  = setup;
    pslverr_d = pslverr_q;
    prdata_d  = prdata_q;
    if (setup)
    begin
      pslverr_d = (sel == bypass_pkg::SEL_NONE);
      if (!pwrite)
      begin
        if (sel == bypass_pkg::SEL_CTRL)
          prdata_d = {24'h0, ctrl_rd};
        else if (sel == bypass_pkg::SEL_SRC)
          prdata_d = {24'h0, src_q};
        else if (sel == bypass_pkg::SEL_STAT)
          prdata_d = {31'h0, stat_q};
        else if (sel == bypass_pkg::SEL_MASK)
          prdata_d = {31'h0, mask_q};
        else
          prdata_d = 32'h0;
      end
    end
  end

  // APB answer storage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end
    else
    begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  assign prdata            = prdata_q;
  assign pready            = pready_q;
  assign pslverr           = pslverr_q;
  assign bypass_out_pin_o  = out_q;
  assign bypass_out_pin_oe = oe_q;
  assign irq_n             = irq_n_q;

  // Checks on the slot behaviour
  property p_evt_src;
    @(posedge pclk) disable iff (!presetn)
    (en_q && ien_q && sd_chg) |=> (stat_q && src_q == SLOT_ADDR);
  endproperty
  a_evt_src: assert property (p_evt_src) else $error("Detect change did not load source");

  property p_evt_irq;
    @(posedge pclk) disable iff (!presetn)
    (en_q && ien_q && sd_chg && mask_q && !wr_mask) |=> !irq_n;
  endproperty
  a_evt_irq: assert property (p_evt_irq) else $error("Detect change did not raise interrupt");

  property p_no_evt;
    @(posedge pclk) disable iff (!presetn)
    (!ien_q && !stat_q) |=> !stat_q;
  endproperty
  a_no_evt: assert property (p_no_evt) else $error("Interrupt raised with irq enable clear");

  property p_drive;
    @(posedge pclk) disable iff (!presetn)
    (en_q && !wr_ctrl && filt_sd) |=> (bypass_out_pin_oe && bypass_out_pin_o == $past(fb_q));
  endproperty
  a_drive: assert property (p_drive) else $error("Bypass pin not following force bypass");

  property p_loss;
    @(posedge pclk) disable iff (!presetn)
    $fell(filt_sd) |-> ##[1:2] !bypass_out_pin_o;
  endproperty
  a_loss: assert property (p_loss) else $error("Bypass pin slow after signal loss");

  property p_auto_clr;
    @(posedge pclk) disable iff (!presetn)
    !filt_sd |=> !fb_q;
  endproperty
  a_auto_clr: assert property (p_auto_clr) else $error("Force bypass not cleared on low detect");

  property p_wr_fb;
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && filt_sd) |=> (fb_q == $past(pwdata[bypass_pkg::BIT_FB]));
  endproperty
  a_wr_fb: assert property (p_wr_fb) else $error("Force bypass write lost while detect high");

  property p_rd_sd;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && sel == bypass_pkg::SEL_CTRL) |=>
      (prdata[bypass_pkg::BIT_SD] == $past(filt_sd) && prdata[5:2] == 4'h0);
  endproperty
  a_rd_sd: assert property (p_rd_sd) else $error("Control read shows wrong detect or reserved");

  property p_rd_strap;
    @(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && sel == bypass_pkg::SEL_CTRL && !en_q) |=>
      (prdata[bypass_pkg::BIT_FB] == $past(filt_out));
  endproperty
  a_rd_strap: assert property (p_rd_strap) else $error("Strap level not visible on read");

  property p_pin_idle;
    @(posedge pclk) disable iff (!presetn)
    (!en_q && !wr_ctrl) |=> !bypass_out_pin_oe;
  endproperty
  a_pin_idle: assert property (p_pin_idle) else $error("Bypass pin driven with enable clear");

  c_evt:   cover property (@(posedge pclk) disable iff (!presetn) sd_evt ##1 !irq_n);
  c_loss:  cover property (@(posedge pclk) disable iff (!presetn) en_q && fb_q ##1 !filt_sd ##2 !bypass_out_pin_o);
  c_read:  cover property (@(posedge pclk) disable iff (!presetn) setup && !pwrite ##1 pready);
  c_clear: cover property (@(posedge pclk) disable iff (!presetn) stat_q && wr_stat ##1 !stat_q);
endmodule // bypass_slot

/* File: verif/ext_bypass_model.sv */
`timescale 1ns/10ps
// Far-side bypass and detect function with its pad pull
module ext_bypass_model (
  input  wire logic drive_o,
  input  wire logic drive_oe,
  input  wire logic strap_low,
  input  wire logic sig_present,
  output logic      pad_level,
  output logic      detect_out,
  output logic      in_bypass
);
  // Pad rests at the pull-up unless strapped low or driven
  assign pad_level  = drive_oe ? drive_o : ~strap_low;
  // Detector output is one while a high-speed signal is present
  assign detect_out = sig_present;
  // A low force input puts the loop into bypass
  assign in_bypass  = ~pad_level;
endmodule // ext_bypass_model

/* File: verif/drive_bypass_slot_control_bench.sv */
`timescale 1ns/10ps
module drive_bypass_slot_control_bench;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rnd;
  logic        pin_i, pin_o, pin_oe, det, irq_n, strap_low, sig_present, in_bypass;
  int          bad_count, samples_checked, n;
  int          seed = 32'h7f9c401d;
  logic [32:0] exp_q[$];

  bypass_slot i_bypass_slot (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .bypass_out_pin_i(pin_i), .bypass_out_pin_o(pin_o),
    .bypass_out_pin_oe(pin_oe), .detect_in_pin(det), .irq_n(irq_n));
  ext_bypass_model i_ext_bypass_model (.drive_o(pin_o), .drive_oe(pin_oe), .strap_low(strap_low),
    .sig_present(sig_present), .pad_level(pin_i), .detect_out(det), .in_bypass(in_bypass));

  // Clock at 50 ns period
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input string what, input logic [32:0] seen, input logic [32:0] expv);
    samples_checked++;
    if (seen !== expv)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, expv, seen);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // One APB transfer; reads leave their expected {pslverr, prdata} in the queue
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [32:0] e);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    if (!w)
      exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20)
    begin
      bad_count++;
      finish_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Bounded wait for the bypass pin or the interrupt to reach a level
  task automatic wait_lvl(input bit on_irq, input logic v, output int cnt);
    cnt = 0;
    while ((on_irq ? irq_n : pin_o) !== v && cnt < 40)
    begin
      @(posedge pclk);
      cnt++;
    end
  endtask

  // Read monitor takes the oldest expectation at each completed read
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      if (exp_q.size() == 0)
        chk("unexpected read", 33'h0, 33'h1);
      else
        chk("read", {pslverr, prdata}, exp_q.pop_front());
    end
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    finish_test();
  end

  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata, strap_low} = '0;
    sig_present = 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("oe", pin_oe, 1'b0);
    chk("irq", irq_n, 1'b1);
    apb(bypass_pkg::OFF_CTRL, 0, 0, 33'h03);
    $display("test reset done");
    strap_low <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(bypass_pkg::OFF_CTRL, 0, 0, 33'h01);
    apb(bypass_pkg::OFF_CTRL, 1, 32'h00, 0);
    apb(bypass_pkg::OFF_CTRL, 1, 32'h80, 0);
    chk("oe", pin_oe, 1'b1);
    chk("pin", pin_o, 1'b0);
    chk("bypassed", in_bypass, 1'b1);
    strap_low <= 1'b0;
    apb(bypass_pkg::OFF_CTRL, 1, 32'hffff_ffbe, 0);
    chk("pin", pin_o, 1'b1);
    apb(bypass_pkg::OFF_CTRL, 0, 0, 33'h83);
    $display("test strap and enable done");
    sig_present <= 1'b0;
    @(posedge pclk);
    wait_lvl(0, 1'b0, n);
    // One edge passed before the wait began, so the bound is one less
    chk("loss latency ok", n <= bypass_pkg::LOSS_MAX_CYC - 1, 1'b1);
    repeat (8) @(posedge pclk);
    chk("irq", irq_n, 1'b1);
    apb(bypass_pkg::OFF_CTRL, 1, 32'h82, 0);
    apb(bypass_pkg::OFF_CTRL, 0, 0, 33'h80);
    apb(bypass_pkg::OFF_STAT, 0, 0, 33'h0);
    sig_present <= 1'b1;
    repeat (8) @(posedge pclk);
    apb(bypass_pkg::OFF_CTRL, 1, 32'hc2, 0);
    apb(bypass_pkg::OFF_CTRL, 0, 0, 33'hc3);
    $display("test loss path done");
    sig_present <= 1'b0;
    @(posedge pclk);
    wait_lvl(1, 1'b0, n);
    chk("irq latency ok", n <= 10, 1'b1);
    apb(bypass_pkg::OFF_SRC, 0, 0, {25'h0, bypass_pkg::SLOT_ADDR_DEF});
    apb(bypass_pkg::OFF_STAT, 0, 0, 33'h1);
    apb(bypass_pkg::OFF_MASK, 1, 32'h0, 0);
    chk("irq masked", irq_n, 1'b1);
    apb(bypass_pkg::OFF_MASK, 1, 32'h1, 0);
    chk("irq unmasked", irq_n, 1'b0);
    apb(bypass_pkg::OFF_STAT, 1, 32'h1, 0);
    chk("irq cleared", irq_n, 1'b1);
    apb(bypass_pkg::OFF_SRC, 0, 0, 33'h0);
    sig_present <= 1'b1;
    @(posedge pclk);
    wait_lvl(1, 1'b0, n);
    chk("irq rise ok", n <= 10, 1'b1);
    apb(bypass_pkg::OFF_STAT, 1, 32'h1, 0);
    $display("test interrupt done");
    apb(8'h10, 1, 32'hffff_ffff, 0);
    apb(8'h10, 0, 0, {1'b1, 32'h0});
    apb(bypass_pkg::OFF_CTRL, 0, 0, 33'hc1);
    $display("test unmapped done");
    // Random control writes with detect steady high
    repeat (8)
    begin
      rnd = $random(seed);
      apb(bypass_pkg::OFF_CTRL, 1, rnd, 0);
      chk("oe", pin_oe, rnd[7]);
      if (rnd[7])
        chk("pin", pin_o, rnd[1]);
      // Released pad needs the filter delay before its strap level reads back
      repeat (4) @(posedge pclk);
      apb(bypass_pkg::OFF_CTRL, 0, 0, {25'h0, rnd[7:6], 4'h0, rnd[7] ? rnd[1] : 1'b1, 1'b1});
    end
    $display("test random done");
    finish_test();
  end
endmodule // drive_bypass_slot_control_bench
